// ### common/serial_channel_map.vh
// How it works
// - led and detector channels shift at 1 mhz
// - three lines each: data, available, clock
// - sender's clock edges mark receiver bit loads
// - led word carries exactly ten bits
// - eight magnitude bits plus two emitter address
// - detector channel carries twelve-bit converter words
// - least significant bit shifted first
// - avionics message is six twelve-bit words
// - end-of-transmission line after sixth word
// - az, el, x, y, z cosines, blank sixth (the code sends host bits 71:60 as the sixth word)
// - avionics bits shift at 100 khz
// - send 4 mhz and three 40 khz clocks
// - one link outbound only, one inbound only
// - refuse host writes until message shifted out
// - raise ready when detector word complete
`ifndef SERIAL_CHANNEL_MAP_VH
`define SERIAL_CHANNEL_MAP_VH

`define CLK_PERIOD_NS      8
`define FAST_BIT_NS        1000
`define FAST_BIT_CYC       (`FAST_BIT_NS / `CLK_PERIOD_NS)
`define SLOW_BIT_NS        10000
`define SLOW_BIT_CYC       (`SLOW_BIT_NS / `CLK_PERIOD_NS)
`define SYS_CLK_NS         250
`define SYS_HALF_CYC       ((`SYS_CLK_NS / `CLK_PERIOD_NS) / 2)
`define SAMPLE_NS          25000
`define SAMPLE_CYC         (`SAMPLE_NS / `CLK_PERIOD_NS)
`define SAMPLE_HALF_CYC    (`SAMPLE_CYC / 2)
`define SAMPLE_FIFTH_CYC   (`SAMPLE_CYC / 5)
`define LED_BITS           10
`define LED_MAG_LSB        0
`define LED_MAG_BITS       8
`define LED_ADDR_LSB       8
`define DET_BITS           12
`define AV_BITS            12
`define AV_WORDS           6
`define AV_EOT_CYC         `SLOW_BIT_CYC

`endif

// ### verilog/serial_shifter.v
`timescale 1ns/1ns
// one outbound word: lsb first, clock rises mid-bit
module serial_shifter #(
    parameter WIDTH   = 10,
    parameter BIT_CYC = 125
) (
    input  wire             core_clk_in,
    input  wire             rst_n_in,
    input  wire             start_in,
    input  wire [WIDTH-1:0] word_in,
    output reg              busy_out,
    output reg              data_out,
    output reg              avail_out,
    output reg              sclk_out
);
    reg [WIDTH-1:0] shift_reg;
    reg [15:0]      cyc_reg;
    reg [4:0]       bit_reg;

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_reg <= {WIDTH{1'b0}};
            cyc_reg   <= 16'h0000;
            bit_reg   <= 5'h00;
            busy_out  <= 1'b0;
            data_out  <= 1'b0;
            avail_out <= 1'b0;
            sclk_out  <= 1'b0;
        end else if (!busy_out) begin
            sclk_out  <= 1'b0;
            avail_out <= 1'b0;
            if (start_in) begin
                busy_out  <= 1'b1;
                shift_reg <= word_in;
                data_out  <= word_in[0];
                avail_out <= 1'b1;
                cyc_reg   <= 16'h0000;
                bit_reg   <= 5'h00;
            end
        end else begin
            // receiver loads on rising sclk, half a bit after data settles
            sclk_out <= (cyc_reg >= (BIT_CYC / 2));
            if (cyc_reg == BIT_CYC - 1) begin
                cyc_reg <= 16'h0000;
                if (bit_reg == WIDTH - 1) begin
                    busy_out  <= 1'b0;
                    avail_out <= 1'b0;
                    sclk_out  <= 1'b0;
                end else begin
                    bit_reg   <= bit_reg + 5'h01;
                    shift_reg <= shift_reg >> 1;
                    data_out  <= shift_reg[1];
                end
            end else begin
                cyc_reg <= cyc_reg + 16'h0001;
            end
        end
    end
endmodule // serial_shifter

// ### verilog/serial_receiver.v
`timescale 1ns/1ns
// inbound detector word; sclk/avail/data arrive unsynchronised
module serial_receiver #(
    parameter WIDTH = 12
) (
    input  wire             core_clk_in,
    input  wire             rst_n_in,
    input  wire             data_in,
    input  wire             avail_in,
    input  wire             sclk_in,
    output reg              done_out,
    output reg  [WIDTH-1:0] word_out
);
    reg [2:0]       s1_reg;
    reg [2:0]       s2_reg;
    reg             sclk_d_reg;
    reg [WIDTH-1:0] shift_reg;
    reg [4:0]       cnt_reg;

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_reg     <= 3'h0;
            s2_reg     <= 3'h0;
            sclk_d_reg <= 1'b0;
            shift_reg  <= {WIDTH{1'b0}};
            cnt_reg    <= 5'h00;
            done_out   <= 1'b0;
            word_out   <= {WIDTH{1'b0}};
        end else begin
            s1_reg     <= {sclk_in, avail_in, data_in};
            s2_reg     <= s1_reg;
            sclk_d_reg <= s2_reg[2];
            done_out   <= 1'b0;
            if (!s2_reg[1]) begin
                cnt_reg <= 5'h00;
            end else if (s2_reg[2] && !sclk_d_reg) begin
                shift_reg <= {s2_reg[0], shift_reg[WIDTH-1:1]};
                if (cnt_reg == WIDTH - 1) begin
                    cnt_reg  <= 5'h00;
                    done_out <= 1'b1;
                    word_out <= {s2_reg[0], shift_reg[WIDTH-1:1]};
                end else begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
            end
        end
    end
endmodule // serial_receiver

// ### verilog/serial_channel_interface.v
`timescale 1ns/1ns
`include "serial_channel_map.vh"
module serial_channel_interface (
    input  wire        core_clk_in,
    input  wire        rst_n_in,
    input  wire        led_wr_in,
    input  wire [7:0]  led_mag_in,
    input  wire [1:0]  led_addr_in,
    input  wire        av_wr_in,
    input  wire [71:0] av_msg_in,
    input  wire        det_ack_in,
    input  wire        det_data_in,
    input  wire        det_avail_in,
    input  wire        det_sclk_in,
    output reg         led_ready_out,
    output reg         av_ready_out,
    output reg         det_ready_out,
    output reg  [11:0] det_word_out,
    output reg         led_data_out,
    output reg         led_avail_out,
    output reg         led_sclk_out,
    output reg         av_data_out,
    output reg         av_avail_out,
    output reg         av_sclk_out,
    output reg         av_eot_out,
    output reg         sys_clk_out,
    output reg         sample_clk_out,
    output reg         sample_a_out,
    output reg         sample_b_out
);
    // -------------------------------------------------------------
    // led channel (outbound only)
    // -------------------------------------------------------------
    wire       led_busy;
    wire       led_d;
    wire       led_a;
    wire       led_c;
    // writes that come while busy are dropped; the host must poll ready
    wire       led_start = led_wr_in && led_ready_out;
    wire [9:0] led_word  = {led_addr_in, led_mag_in};

    serial_shifter #(
        .WIDTH   (`LED_BITS),
        .BIT_CYC (`FAST_BIT_CYC)
    ) led_tx (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .start_in    (led_start),
        .word_in     (led_word),
        .busy_out    (led_busy),
        .data_out    (led_d),
        .avail_out   (led_a),
        .sclk_out    (led_c)
    );

    // -------------------------------------------------------------
    // avionics channel, six words then eot
    // -------------------------------------------------------------
    localparam AV_IDLE = 2'h0;
    localparam AV_WORD = 2'h1;
    localparam AV_WAIT = 2'h2;
    localparam AV_EOT  = 2'h3;

    reg  [1:0]  av_state_reg;
    reg  [2:0]  av_idx_reg;
    reg  [71:0] av_msg_reg;
    reg  [15:0] av_cnt_reg;
    reg         av_go_reg;
    wire        av_busy;
    wire        av_d;
    wire        av_a;
    wire        av_c;
    // message slots in send order; the sixth is the spare word
    wire [11:0] az_word    = av_msg_reg[11:0];
    wire [11:0] el_word    = av_msg_reg[23:12];
    wire [11:0] xcos_word  = av_msg_reg[35:24];
    wire [11:0] ycos_word  = av_msg_reg[47:36];
    wire [11:0] zcos_word  = av_msg_reg[59:48];
    wire [11:0] spare_word = av_msg_reg[71:60];
    reg  [11:0] av_word;

    // slot picked by index, so the held message stays intact for the whole send
    always @* begin
        case (av_idx_reg)
            3'h0:    av_word = az_word;
            3'h1:    av_word = el_word;
            3'h2:    av_word = xcos_word;
            3'h3:    av_word = ycos_word;
            3'h4:    av_word = zcos_word;
            3'h5:    av_word = spare_word;
            default: av_word = 12'h000;
        endcase
    end

    serial_shifter #(
        .WIDTH   (`AV_BITS),
        .BIT_CYC (`SLOW_BIT_CYC)
    ) av_tx (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .start_in    (av_go_reg),
        .word_in     (av_word),
        .busy_out    (av_busy),
        .data_out    (av_d),
        .avail_out   (av_a),
        .sclk_out    (av_c)
    );

    // message order: word0 az, el, x, y, z, word5 spare from host bits 71:60
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            av_state_reg <= AV_IDLE;
            av_idx_reg   <= 3'h0;
            av_msg_reg   <= 72'h0;
            av_cnt_reg   <= 16'h0000;
            av_go_reg    <= 1'b0;
            av_eot_out   <= 1'b0;
        end else begin
            av_go_reg <= 1'b0;
            case (av_state_reg)
                AV_IDLE: begin
                    av_eot_out <= 1'b0;
                    if (av_wr_in && av_ready_out) begin
                        av_msg_reg   <= av_msg_in;
                        av_idx_reg   <= 3'h0;
                        av_go_reg    <= 1'b1;
                        av_state_reg <= AV_WORD;
                    end
                end
                AV_WORD: begin
                    av_state_reg <= AV_WAIT;
                end
                AV_WAIT: begin
                    // go still high means the shifter has not yet seen the start
                    if (!av_busy && !av_go_reg) begin
                        if (av_idx_reg == `AV_WORDS - 1) begin
                            av_eot_out   <= 1'b1;
                            av_cnt_reg   <= 16'h0000;
                            av_state_reg <= AV_EOT;
                        end else begin
                            av_idx_reg   <= av_idx_reg + 3'h1;
                            av_go_reg    <= 1'b1;
                            av_state_reg <= AV_WORD;
                        end
                    end
                end
                AV_EOT: begin
                    // eot held one bit period so slow receivers see it
                    if (av_cnt_reg == `AV_EOT_CYC - 1) begin
                        av_eot_out   <= 1'b0;
                        av_state_reg <= AV_IDLE;
                    end else begin
                        av_cnt_reg <= av_cnt_reg + 16'h0001;
                    end
                end
                default: av_state_reg <= AV_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------
    // detector channel (inbound only)
    // -------------------------------------------------------------
    wire        det_done;
    wire [11:0] det_word;

    // inbound lines pass two flops inside the receiver before use
    serial_receiver #(
        .WIDTH (`DET_BITS)
    ) det_rx (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .data_in     (det_data_in),
        .avail_in    (det_avail_in),
        .sclk_in     (det_sclk_in),
        .done_out    (det_done),
        .word_out    (det_word)
    );

    // -------------------------------------------------------------
    // host write acceptance
    // -------------------------------------------------------------
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_ready_out <= 1'b0;
            av_ready_out  <= 1'b0;
        end else begin
            // ready drops the cycle a write is taken
            led_ready_out <= !led_busy && !led_start;
            av_ready_out  <= (av_state_reg == AV_IDLE) &&
                             !(av_wr_in && av_ready_out);
        end
    end

    // -------------------------------------------------------------
    // detector word status for the host
    // -------------------------------------------------------------
    // a new word beats an ack in the same cycle; the older word is lost
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            det_ready_out <= 1'b0;
            det_word_out  <= 12'h000;
        end else if (det_done) begin
            det_ready_out <= 1'b1;
            det_word_out  <= det_word;
        end else if (det_ack_in) begin
            det_ready_out <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // led line registers
    // -------------------------------------------------------------
    // one flop stage so every line leaves the block from a register
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_data_out  <= 1'b0;
            led_avail_out <= 1'b0;
            led_sclk_out  <= 1'b0;
        end else begin
            led_data_out  <= led_d;
            led_avail_out <= led_a;
            led_sclk_out  <= led_c;
        end
    end

    // -------------------------------------------------------------
    // avionics line registers
    // -------------------------------------------------------------
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            av_data_out  <= 1'b0;
            av_avail_out <= 1'b0;
            av_sclk_out  <= 1'b0;
        end else begin
            av_data_out  <= av_d;
            av_avail_out <= av_a;
            av_sclk_out  <= av_c;
        end
    end

    // -------------------------------------------------------------
    // system clock: 4 mhz
    // -------------------------------------------------------------
    // half period rounds down to whole cycles, so the clock runs a little fast
    reg [7:0]  sys_cnt_reg;

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_cnt_reg <= 8'h00;
            sys_clk_out <= 1'b0;
        end else if (sys_cnt_reg == `SYS_HALF_CYC - 1) begin
            sys_cnt_reg <= 8'h00;
            sys_clk_out <= !sys_clk_out;
        end else begin
            sys_cnt_reg <= sys_cnt_reg + 8'h01;
        end
    end

    // -------------------------------------------------------------
    // 40 khz sample timing
    // -------------------------------------------------------------
    reg [15:0] smp_cnt_reg;

    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            smp_cnt_reg <= 16'h0000;
        end else if (smp_cnt_reg == `SAMPLE_CYC - 1) begin
            smp_cnt_reg <= 16'h0000;
        end else begin
            smp_cnt_reg <= smp_cnt_reg + 16'h0001;
        end
    end

    // 50% sample clock
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_clk_out <= 1'b0;
        end else begin
            sample_clk_out <= (smp_cnt_reg < `SAMPLE_HALF_CYC);
        end
    end

    // 20% pulse in the first half of the period
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_a_out <= 1'b0;
        end else begin
            sample_a_out <= (smp_cnt_reg < `SAMPLE_FIFTH_CYC);
        end
    end

    // 20% pulse in the second half, opposite in phase to the first
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_b_out <= 1'b0;
        end else begin
            sample_b_out <= (smp_cnt_reg >= `SAMPLE_HALF_CYC) &&
                            (smp_cnt_reg < `SAMPLE_HALF_CYC + `SAMPLE_FIFTH_CYC);
        end
    end
endmodule // serial_channel_interface

// ### verification/sci_checker.sv
`timescale 1ns/1ns
module sci_checker (
    input wire core_clk_in,
    input wire rst_n_in,
    input wire led_wr_in,
    input wire led_ready_out,
    input wire led_avail_out,
    input wire led_sclk_out,
    input wire av_avail_out,
    input wire av_eot_out,
    input wire det_ack_in,
    input wire det_ready_out,
    input wire sample_clk_out,
    input wire sample_a_out
);
    // ----
    // frame counters
    // ----
    reg [10:0] hi_reg;
    reg [10:0] gap_reg;
    reg [3:0]  bits_reg;
    reg [2:0]  words_reg;
    reg [10:0] eot_reg;
    reg        sclk_reg;
    reg        av_reg;
    always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {hi_reg, gap_reg, bits_reg, words_reg, eot_reg, sclk_reg, av_reg} <= 0;
        end else begin
            sclk_reg  <= led_sclk_out;
            av_reg    <= av_avail_out;
            hi_reg    <= led_avail_out ? hi_reg + 11'h1 : 11'h0;
            gap_reg   <= (led_sclk_out && !sclk_reg) ? 11'h1 : gap_reg + 11'h1;
            bits_reg  <= !led_avail_out ? 4'h0 : bits_reg + {3'h0, led_sclk_out && !sclk_reg};
            words_reg <= av_eot_out ? 3'h0 : words_reg + {2'h0, av_avail_out && !av_reg};
            eot_reg   <= av_eot_out ? eot_reg + 11'h1 : 11'h0;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_led_launch;
        !led_ready_out ##1 led_avail_out;
    endsequence
    a_led_take_busy: assert property (led_wr_in && led_ready_out |=> s_led_launch)
        else $error("led write not launched");
    a_led_lock_out: assert property (led_avail_out |-> !led_ready_out)
        else $error("led ready during frame");
    a_led_frame_len: assert property ($fell(led_avail_out) |-> hi_reg == 11'h4e2)
        else $error("led frame length wrong");
    a_led_bit_count: assert property ($fell(led_avail_out) |-> bits_reg == 4'ha)
        else $error("led bit count wrong");
    a_led_bit_rate: assert property ($rose(led_sclk_out) && bits_reg != 4'h0 |->
        gap_reg == 11'h07d)
        else $error("led bit spacing wrong");
    a_sclk_in_frame: assert property (led_sclk_out |-> led_avail_out)
        else $error("led clock outside frame");
    a_av_six_words: assert property ($rose(av_eot_out) |-> words_reg == 3'h6)
        else $error("avionics word count wrong");
    a_av_eot_len: assert property ($fell(av_eot_out) |-> eot_reg == 11'h4e2)
        else $error("end of transmission length wrong");
    a_det_ready_hold: assert property (det_ready_out && !det_ack_in |=> det_ready_out)
        else $error("detector ready dropped");
    a_sample_phase: assert property ($rose(sample_a_out) |-> $rose(sample_clk_out))
        else $error("sample pulse out of phase");
endmodule // sci_checker
bind serial_channel_interface sci_checker u_chk (.core_clk_in, .rst_n_in, .led_wr_in,
    .led_ready_out, .led_avail_out, .led_sclk_out, .av_avail_out, .av_eot_out,
    .det_ack_in, .det_ready_out, .sample_clk_out, .sample_a_out);

// ### verification/sensor_unit_model.sv
`timescale 1ns/1ns
module sensor_unit_model (
    input  wire led_data_in,
    input  wire led_avail_in,
    input  wire led_sclk_in,
    input  wire av_data_in,
    input  wire av_avail_in,
    input  wire av_sclk_in,
    output reg  det_data_out,
    output reg  det_avail_out,
    output reg  det_sclk_out
);
    // ----
    // receivers and detector sender
    // ----
    reg [9:0]  led_sr;
    reg [11:0] av_sr;
    reg [71:0] av_msg;
    integer    led_n = 0;
    integer    av_n = 0;
    initial {det_data_out, det_avail_out, det_sclk_out} = 3'h0;
    always @(posedge led_avail_in) led_n = 0;
    always @(posedge led_sclk_in) begin
        if (led_avail_in) begin
            led_sr = {led_data_in, led_sr[9:1]};
            led_n = led_n + 1;
        end
    end
    always @(posedge av_sclk_in) begin
        if (av_avail_in) begin
            av_sr = {av_data_in, av_sr[11:1]};
            av_n = av_n + 1;
        end
    end
    always @(negedge av_avail_in) av_msg = {av_sr, av_msg[71:12]};
    // clock stands still between words; data shows inverse of last bit
    task send_word(input [11:0] w);
        integer i;
        begin
            det_avail_out = 1;
            for (i = 0; i < 12; i = i + 1) begin
                det_data_out = w[i];
                #32 det_sclk_out = 1;
                #32 det_sclk_out = 0;
            end
            det_data_out = ~w[11];
            #32 det_avail_out = 0;
        end
    endtask
endmodule // sensor_unit_model

// ### verification/tb_serial_channel_interface.sv
`timescale 1ns/1ns
`include "serial_channel_map.vh"
module tb_serial_channel_interface;
    reg         core_clk_in = 0;
    reg         rst_n_in = 0;
    reg         led_wr_in = 0;
    reg  [7:0]  led_mag_in = 0;
    reg  [1:0]  led_addr_in = 0;
    reg         av_wr_in = 0;
    reg  [71:0] av_msg_in = 0;
    reg         det_ack_in = 0;
    wire [11:0] det_word_out;
    wire        det_data_in, det_avail_in, det_sclk_in, led_ready_out, av_ready_out;
    wire        det_ready_out, led_data_out, led_avail_out, led_sclk_out, av_data_out;
    wire        av_avail_out, av_sclk_out, av_eot_out, sys_clk_out, sample_clk_out;
    wire        sample_a_out, sample_b_out;
    integer     n_mismatch = 0;
    integer     cmp_count = 0;
    serial_channel_interface DUT (.core_clk_in, .rst_n_in, .led_wr_in, .led_mag_in,
        .led_addr_in, .av_wr_in, .av_msg_in, .det_ack_in, .det_data_in, .det_avail_in,
        .det_sclk_in, .led_ready_out, .av_ready_out, .det_ready_out, .det_word_out,
        .led_data_out, .led_avail_out, .led_sclk_out, .av_data_out, .av_avail_out,
        .av_sclk_out, .av_eot_out, .sys_clk_out, .sample_clk_out, .sample_a_out,
        .sample_b_out);
    sensor_unit_model peer (.led_data_in(led_data_out), .led_avail_in(led_avail_out),
        .led_sclk_in(led_sclk_out), .av_data_in(av_data_out), .av_avail_in(av_avail_out),
        .av_sclk_in(av_sclk_out), .det_data_out(det_data_in),
        .det_avail_out(det_avail_in), .det_sclk_out(det_sclk_in));
    always #4 core_clk_in = ~core_clk_in;
    // ----
    // checking and tests
    // ----
    task check(input string nm, input [71:0] seen, input [71:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            n_mismatch = n_mismatch + 1;
        end
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task t_reset;
        integer k;
        integer t;
        reg p;
        begin
            repeat (6) @(negedge core_clk_in);
            check("rst_ready", {led_ready_out, av_ready_out}, 0);
            rst_n_in = 1;
            @(negedge core_clk_in);
            check("ready", {led_ready_out, av_ready_out}, 2'h3);
            t = 0;
            p = sys_clk_out;
            for (k = 0; k < 150; k = k + 1) begin
                @(negedge core_clk_in);
                if (sys_clk_out !== p) t = t + 1;
                p = sys_clk_out;
            end
            check("sys_toggles", t, 10);
            $display("reset test done");
        end
    endtask
    task t_led;
        integer a;
        integer k;
        begin
            for (a = 0; a < 4; a = a + 1) begin
                led_mag_in = 8'h96 >> a;
                led_addr_in = a[1:0];
                led_wr_in = 1;
                @(negedge core_clk_in);
                led_wr_in = 0;
                repeat (2) @(negedge core_clk_in);
                check("led_busy", led_ready_out, 0);
                led_mag_in = 8'hff;
                led_wr_in = 1;
                @(negedge core_clk_in);
                led_wr_in = 0;
                for (k = 0; k < 1400 && led_ready_out !== 1; k = k + 1) @(negedge core_clk_in);
                check("led_ready", led_ready_out, 1);
                check("led_word", peer.led_sr, {a[1:0], 8'h96 >> a});
                check("led_bits", peer.led_n, 10);
            end
            $display("led test done");
        end
    endtask
    task t_av;
        integer k;
        reg e;
        reg [71:0] m;
        begin
            e = 0;
            m = {12'h000, 12'h9c4, 12'h3e1, 12'h7f0, 12'h801, 12'h5a5};
            av_msg_in = m;
            av_wr_in = 1;
            @(negedge core_clk_in);
            av_wr_in = 0;
            repeat (2) @(negedge core_clk_in);
            check("av_busy", av_ready_out, 0);
            av_msg_in = ~m;
            av_wr_in = 1;
            @(negedge core_clk_in);
            av_wr_in = 0;
            for (k = 0; k < 95000 && av_ready_out !== 1; k = k + 1) begin
                @(negedge core_clk_in);
                if (av_eot_out === 1) e = 1;
            end
            check("av_ready", av_ready_out, 1);
            check("av_msg", peer.av_msg, m);
            check("av_bits", peer.av_n, 72);
            check("av_eot", e, 1);
            check("av_slow", k > 91000, 1);
            $display("avionics test done");
        end
    endtask
    task t_det;
        integer k;
        begin
            peer.send_word(12'ha53);
            for (k = 0; k < 20 && det_ready_out !== 1; k = k + 1) @(negedge core_clk_in);
            check("det_ready", det_ready_out, 1);
            check("det_word", det_word_out, 12'ha53);
            peer.send_word(12'h3ac);
            repeat (4) @(negedge core_clk_in);
            check("det_word2", det_word_out, 12'h3ac);
            det_ack_in = 1;
            @(negedge core_clk_in);
            det_ack_in = 0;
            @(negedge core_clk_in);
            check("det_clear", det_ready_out, 0);
            $display("detector test done");
        end
    endtask
    task t_sample;
        integer k;
        integer ha;
        integer hb;
        integer hc;
        begin
            ha = 0;
            hb = 0;
            hc = 0;
            for (k = 0; k < 4000 && sample_b_out !== 0; k = k + 1) @(negedge core_clk_in);
            for (k = 0; k < 4000 && sample_b_out !== 1; k = k + 1) @(negedge core_clk_in);
            check("smp_phase", {sample_clk_out, sample_a_out}, 2'h0);
            for (k = 0; k < `SAMPLE_CYC; k = k + 1) begin
                ha = ha + sample_a_out;
                hb = hb + sample_b_out;
                hc = hc + sample_clk_out;
                @(negedge core_clk_in);
            end
            check("smp_a_len", ha, `SAMPLE_FIFTH_CYC);
            check("smp_b_len", hb, `SAMPLE_FIFTH_CYC);
            check("smp_clk_len", hc, `SAMPLE_HALF_CYC);
            $display("sample test done");
        end
    endtask
    initial begin
        t_reset;
        fork
            t_av;
            begin
                t_led;
                t_det;
                t_sample;
            end
        join
        results;
    end
    // whole run is about 91500 cycles, dominated by the avionics message
    initial begin
        #768000;
        n_mismatch = n_mismatch + 1;
        results;
    end
endmodule // tb_serial_channel_interface
